// *** src/lcdd_pkg.sv ***
package lcdd_pkg;

   // ************************************************************
   // Geometry
   // ************************************************************
   localparam int PAGES     = 9;
   localparam int COLS      = 100;
   localparam int RAM_WORDS = PAGES * COLS;
   localparam int RAM_AW    = 10;

   // ************************************************************
   // Timing in mclk cycles, FIFO depth in entries
   // ************************************************************
   localparam int INIT_CYCLES = 16;
   localparam int BUSY_CYCLES = 1;
   localparam int FIFO_DEPTH  = 4;

   // ************************************************************
   // Status byte bit positions
   // ************************************************************
   localparam int ST_BUSY_BIT  = 7;
   localparam int ST_SEG_BIT   = 6;
   localparam int ST_OFF_BIT   = 5;
   localparam int ST_RESET_BIT = 4;

   // ************************************************************
   // Command patterns
   // ************************************************************
   localparam logic [6:0] PAT_DISP     = 7'h57;
   localparam logic [1:0] PAT_START    = 2'h1;
   localparam logic [7:0] PAT_REFMODE  = 8'h81;
   localparam logic [2:0] PAT_REFREG   = 3'h4;
   localparam logic [3:0] PAT_PAGE     = 4'hB;
   localparam logic [4:0] PAT_COLHI    = 5'h02;
   localparam logic [3:0] PAT_COLLO    = 4'h0;
   localparam logic [6:0] PAT_SEGDIR   = 7'h50;
   localparam logic [6:0] PAT_INVERT   = 7'h53;
   localparam logic [6:0] PAT_ALLON    = 7'h52;
   localparam logic [6:0] PAT_BIAS     = 7'h51;
   localparam logic [7:0] PAT_RMW_SET  = 8'hE0;
   localparam logic [7:0] PAT_RMW_CLR  = 8'hEE;

   // ************************************************************
   // Values after reset, and the idle read byte
   // ************************************************************
   localparam logic [5:0] RST_START = 6'h00;
   localparam logic [4:0] RST_REFV  = 5'h00;
   localparam logic [3:0] RST_PAGE  = 4'h0;
   localparam logic [6:0] RST_COL   = 7'h00;
   localparam logic [7:0] IDLE_BYTE = 8'h00;

   typedef enum {
      C_NONE, C_DISP, C_START, C_REFMODE, C_REFREG, C_PAGE, C_COLHI,
      C_COLLO, C_SEGDIR, C_INVERT, C_ALLON, C_BIAS, C_RMW_SET, C_RMW_CLR
   } lcdd_cmd_t;

endpackage : lcdd_pkg

// *** src/lcdd_decoder.sv ***
// Functional notes
// - Data read returns byte, column plus one
// - Serial mode offers no RAM read path
// - Data write stores byte, column plus one
// - Status byte: busy, seg, off, reset
// - Busy set ignores instructions; host waits
// - Seg status reads one for normal order
// - Off status reads one when disabled
// - Reset status high during pin initialisation
// - Display enable command, bit zero
// - Start line command, six bits
// - Two-byte reference sequence, pending mode
// - Pending byte 100xxxxx stores reference
// - Page command loads page pointer
// - Page change leaves panel unchanged
// - Column loaded as upper and lower parts
// - Segment direction command
// - Pixel polarity command
// - All-on command overrides polarity
// - Bias select command
// - Modify-read stops read increment
// - Release restores saved column
`timescale 1ns/1ps
`default_nettype none

// ************************************************************
// Response FIFO
// ************************************************************
module lcdd_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input  wire logic         mclk,       // Clock
   input  wire logic         resetn,     // Async reset, low
   input  wire logic         in_valid,   // Push request
   output logic              in_ready,   // Room available
   input  wire logic [W-1:0] in_data,    // Push data
   output logic              out_valid,  // Head valid
   input  wire logic         out_ready,  // Pop request
   output logic      [W-1:0] out_data    // Head data
);
   localparam int AW = (D > 1) ? $clog2(D) : 1;

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } lcdd_fifo_st_t;

   lcdd_fifo_st_t      st_ff;
   lcdd_fifo_st_t      nxt_st;
   logic     [W-1:0]   mem [0:D-1];
   logic               push;
   logic               pop;

   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign in_ready  = (st_ff.cnt < (AW+1)'(D));
   assign out_valid = (st_ff.cnt != '0);
   assign out_data  = mem[st_ff.rp];

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.wp = (st_ff.wp == AW'(D-1)) ? '0 : st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = (st_ff.rp == AW'(D-1)) ? '0 : st_ff.rp + 1'b1;
      end
      if (push && !pop) begin
         nxt_st.cnt = st_ff.cnt + 1'b1;
      end else if (pop && !push) begin
         nxt_st.cnt = st_ff.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[st_ff.wp] <= in_data;
      end
   end
endmodule : lcdd_fifo

// ************************************************************
// Instruction decoder
// ************************************************************
module lcdd_decoder #(
   parameter int INIT_CYCLES = lcdd_pkg::INIT_CYCLES,
   parameter int FIFO_DEPTH  = lcdd_pkg::FIFO_DEPTH
) (
   input  wire logic       mclk,          // 200 MHz clock
   input  wire logic       resetn,        // Async reset, low
   input  wire logic       hw_reset_n,    // Reset pin, low
   input  wire logic       serial_sel,    // Serial host selected
   input  wire logic       req_valid,     // Host access request
   output logic            req_ready,     // Request may be taken
   input  wire logic       req_cmd_data_select, // 1 data, 0 command
   input  wire logic       req_rw,        // 1 read, 0 write
   input  wire logic [7:0] req_wdata,     // Write byte
   output logic            rsp_valid,     // Read byte available
   input  wire logic       rsp_ready,     // Host takes read byte
   output logic      [7:0] rsp_data,      // Read byte
   input  wire logic [3:0] scan_page,     // Panel scan page
   input  wire logic [6:0] scan_col,      // Panel scan column
   output logic      [7:0] scan_data,     // Panel scan byte
   output logic            display_on,    // Panel enabled
   output logic            seg_reverse,   // Reversed segment order
   output logic            pixel_invert,  // Inverted polarity
   output logic            all_pixels_on, // Force all pixels
   output logic            bias_fifth,    // 1/5 bias, else 1/6
   output logic      [5:0] start_line,    // Display start line
   output logic      [4:0] refv_param,    // Reference parameter
   output logic            busy,          // Busy flag
   output logic            init_busy      // Pin reset in progress
);
   localparam int CW = $clog2(INIT_CYCLES + 1) + 1;

   typedef struct packed {
      logic          hwr_s1;
      logic          hwr_s2;
      logic          init;
      logic [CW-1:0] init_cnt;
      logic [1:0]    busy_cnt;
      logic          bsy;
      logic          rdy;
      logic          disp_on;
      logic          seg_rev;
      logic          inv;
      logic          allon;
      logic          bias;
      logic [5:0]    start;
      logic [4:0]    refv;
      logic          refv_pend;
      logic [3:0]    page;
      logic [6:0]    col;
      logic          rmw;
      logic [6:0]    rmw_col;
      logic [7:0]    rbuf;
      logic          push;
      logic [7:0]    push_data;
      logic [7:0]    scan;
   } lcdd_st_t;

   lcdd_st_t          st_ff;
   lcdd_st_t          nxt_st;
   logic [7:0]        ram [0:lcdd_pkg::RAM_WORDS-1];
   logic              fifo_in_ready;
   logic              take;
   logic              is_busy;
   lcdd_pkg::lcdd_cmd_t cmd;
   logic              ram_we;
   logic [lcdd_pkg::RAM_AW-1:0] acc_idx;
   logic              acc_ok;

   // ************************************************************
   // Helpers
   // ************************************************************
   function automatic logic addr_ok(input logic [3:0] pg,
                                    input logic [6:0] cl);
      addr_ok = (32'(pg) < lcdd_pkg::PAGES) && (32'(cl) < lcdd_pkg::COLS);
   endfunction : addr_ok

   function automatic logic [lcdd_pkg::RAM_AW-1:0] ram_idx(
      input logic [3:0] pg,
      input logic [6:0] cl);
      ram_idx = lcdd_pkg::RAM_AW'(32'(pg) * lcdd_pkg::COLS + 32'(cl));
   endfunction : ram_idx

   function automatic lcdd_pkg::lcdd_cmd_t decode(input logic [7:0] b,
                                                  input logic       pend);
      decode = lcdd_pkg::C_NONE;
      if (pend && b[7:5] == lcdd_pkg::PAT_REFREG) begin
         decode = lcdd_pkg::C_REFREG;
      end else if (b[7:1] == lcdd_pkg::PAT_DISP) begin
         decode = lcdd_pkg::C_DISP;
      end else if (b[7:6] == lcdd_pkg::PAT_START) begin
         decode = lcdd_pkg::C_START;
      end else if (b == lcdd_pkg::PAT_REFMODE) begin
         decode = lcdd_pkg::C_REFMODE;
      end else if (b[7:4] == lcdd_pkg::PAT_PAGE) begin
         decode = lcdd_pkg::C_PAGE;
      end else if (b[7:3] == lcdd_pkg::PAT_COLHI) begin
         decode = lcdd_pkg::C_COLHI;
      end else if (b[7:4] == lcdd_pkg::PAT_COLLO) begin
         decode = lcdd_pkg::C_COLLO;
      end else if (b[7:1] == lcdd_pkg::PAT_SEGDIR) begin
         decode = lcdd_pkg::C_SEGDIR;
      end else if (b[7:1] == lcdd_pkg::PAT_INVERT) begin
         decode = lcdd_pkg::C_INVERT;
      end else if (b[7:1] == lcdd_pkg::PAT_ALLON) begin
         decode = lcdd_pkg::C_ALLON;
      end else if (b[7:1] == lcdd_pkg::PAT_BIAS) begin
         decode = lcdd_pkg::C_BIAS;
      end else if (b == lcdd_pkg::PAT_RMW_SET) begin
         decode = lcdd_pkg::C_RMW_SET;
      end else if (b == lcdd_pkg::PAT_RMW_CLR) begin
         decode = lcdd_pkg::C_RMW_CLR;
      end
   endfunction : decode

   // ************************************************************
   // Read-back FIFO
   // ************************************************************
   lcdd_fifo #(
      .W (8),
      .D (FIFO_DEPTH)
   ) u_rsp_fifo (
      .mclk      (mclk),
      .resetn    (resetn),
      .in_valid  (st_ff.push),
      .in_ready  (fifo_in_ready),
      .in_data   (st_ff.push_data),
      .out_valid (rsp_valid),
      .out_ready (rsp_ready),
      .out_data  (rsp_data)
   );

   assign take    = req_valid && st_ff.rdy;
   assign is_busy = st_ff.bsy;
   assign cmd     = decode(req_wdata, st_ff.refv_pend);
   assign acc_ok  = addr_ok(st_ff.page, st_ff.col);
   assign acc_idx = ram_idx(st_ff.page, st_ff.col);
   assign ram_we  = take && !is_busy && req_cmd_data_select && !req_rw
                    && acc_ok;

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.hwr_s1 = hw_reset_n;
      nxt_st.hwr_s2 = st_ff.hwr_s1;
      nxt_st.push   = 1'b0;
      if (st_ff.busy_cnt != '0) begin
         nxt_st.busy_cnt = st_ff.busy_cnt - 1'b1;
      end
      // Room for the push of this cycle and the one in flight
      nxt_st.rdy = fifo_in_ready && !st_ff.push && !(take && req_rw);
      // Panel side reads its own address, not the host pointer
      nxt_st.scan = addr_ok(scan_page, scan_col) ?
                    ram[ram_idx(scan_page, scan_col)] :
                    lcdd_pkg::IDLE_BYTE;

      if (st_ff.init) begin
         if (st_ff.init_cnt != '0) begin
            nxt_st.init_cnt = st_ff.init_cnt - 1'b1;
         end else begin
            nxt_st.init = 1'b0;
         end
      end

      if (take && req_rw) begin
         nxt_st.push      = 1'b1;
         nxt_st.push_data = lcdd_pkg::IDLE_BYTE;
         if (!req_cmd_data_select) begin
            nxt_st.push_data[lcdd_pkg::ST_BUSY_BIT]  = is_busy;
            nxt_st.push_data[lcdd_pkg::ST_SEG_BIT]   = !st_ff.seg_rev;
            nxt_st.push_data[lcdd_pkg::ST_OFF_BIT]   = !st_ff.disp_on;
            nxt_st.push_data[lcdd_pkg::ST_RESET_BIT] = st_ff.init;
         end else if (!is_busy && !serial_sel) begin
            // Pipelined read: answer last latch, refill from pointer
            nxt_st.push_data = st_ff.rbuf;
            nxt_st.rbuf      = acc_ok ? ram[acc_idx] :
                               lcdd_pkg::IDLE_BYTE;
            if (!st_ff.rmw) begin
               nxt_st.col = st_ff.col + 7'h01;
            end
         end
      end else if (take && !is_busy && req_cmd_data_select) begin
         nxt_st.col      = st_ff.col + 7'h01;
         nxt_st.busy_cnt = 2'(lcdd_pkg::BUSY_CYCLES);
      end else if (take && !is_busy) begin
         nxt_st.busy_cnt  = 2'(lcdd_pkg::BUSY_CYCLES);
         nxt_st.refv_pend = 1'b0;
         case (cmd)
            lcdd_pkg::C_DISP: begin
               nxt_st.disp_on = req_wdata[0];
            end
            lcdd_pkg::C_START: begin
               nxt_st.start = req_wdata[5:0];
            end
            lcdd_pkg::C_REFMODE: begin
               nxt_st.refv_pend = 1'b1;
            end
            lcdd_pkg::C_REFREG: begin
               nxt_st.refv = req_wdata[4:0];
            end
            lcdd_pkg::C_PAGE: begin
               nxt_st.page = req_wdata[3:0];
            end
            lcdd_pkg::C_COLHI: begin
               nxt_st.col = {req_wdata[2:0], st_ff.col[3:0]};
            end
            lcdd_pkg::C_COLLO: begin
               nxt_st.col = {st_ff.col[6:4], req_wdata[3:0]};
            end
            lcdd_pkg::C_SEGDIR: begin
               nxt_st.seg_rev = req_wdata[0];
            end
            lcdd_pkg::C_INVERT: begin
               nxt_st.inv = req_wdata[0];
            end
            lcdd_pkg::C_ALLON: begin
               nxt_st.allon = req_wdata[0];
            end
            lcdd_pkg::C_BIAS: begin
               nxt_st.bias = req_wdata[0];
            end
            lcdd_pkg::C_RMW_SET: begin
               nxt_st.rmw     = 1'b1;
               nxt_st.rmw_col = st_ff.col;
            end
            lcdd_pkg::C_RMW_CLR: begin
               if (st_ff.rmw) begin
                  nxt_st.col = st_ff.rmw_col;
               end
               nxt_st.rmw = 1'b0;
            end
            default: begin
               nxt_st.busy_cnt = st_ff.busy_cnt;
            end
         endcase
      end

      // Pin reset returns settings to defaults and restarts init
      if (!st_ff.hwr_s2) begin
         nxt_st.init      = 1'b1;
         nxt_st.init_cnt  = CW'(INIT_CYCLES);
         nxt_st.busy_cnt  = '0;
         nxt_st.disp_on   = 1'b0;
         nxt_st.seg_rev   = 1'b0;
         nxt_st.inv       = 1'b0;
         nxt_st.allon     = 1'b0;
         nxt_st.bias      = 1'b0;
         nxt_st.start     = lcdd_pkg::RST_START;
         nxt_st.refv      = lcdd_pkg::RST_REFV;
         nxt_st.refv_pend = 1'b0;
         nxt_st.page      = lcdd_pkg::RST_PAGE;
         nxt_st.col       = lcdd_pkg::RST_COL;
         nxt_st.rmw       = 1'b0;
      end
      nxt_st.bsy = nxt_st.init || nxt_st.busy_cnt != '0;
   end

   // ************************************************************
   // Registers
   // ************************************************************
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         st_ff          <= '0;
         st_ff.init     <= 1'b1;
         st_ff.bsy      <= 1'b1;
         st_ff.init_cnt <= CW'(INIT_CYCLES);
         st_ff.start    <= lcdd_pkg::RST_START;
         st_ff.refv     <= lcdd_pkg::RST_REFV;
         st_ff.page     <= lcdd_pkg::RST_PAGE;
         st_ff.col      <= lcdd_pkg::RST_COL;
      end else begin
         st_ff <= nxt_st;
      end
   end

   always_ff @(posedge mclk) begin
      if (ram_we) begin
         ram[acc_idx] <= req_wdata;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign req_ready     = st_ff.rdy;
   assign scan_data     = st_ff.scan;
   assign display_on    = st_ff.disp_on;
   assign seg_reverse   = st_ff.seg_rev;
   assign pixel_invert  = st_ff.inv;
   assign all_pixels_on = st_ff.allon;
   assign bias_fifth    = st_ff.bias;
   assign start_line    = st_ff.start;
   assign refv_param    = st_ff.refv;
   assign busy          = st_ff.bsy;
   assign init_busy     = st_ff.init;
endmodule : lcdd_decoder

`default_nettype wire

// *** testbench/lcdd_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcdd_assertions (
   input wire logic       mclk,                // Clock
   input wire logic       resetn,              // Reset, low
   input wire logic       hw_reset_n,          // Reset pin
   input wire logic       serial_sel,          // Serial host
   input wire logic       req_valid,           // Request
   input wire logic       req_ready,           // Taken
   input wire logic       req_cmd_data_select, // Data/command
   input wire logic       req_rw,              // Read/write
   input wire logic [7:0] req_wdata,           // Write byte
   input wire logic       rsp_valid,           // Read ready
   input wire logic       rsp_ready,           // Pop
   input wire logic [7:0] rsp_data,            // Read byte
   input wire logic [3:0] scan_page,           // Scan page
   input wire logic [6:0] scan_col,            // Scan column
   input wire logic [7:0] scan_data,           // Scan byte
   input wire logic       display_on,          // Panel on
   input wire logic       seg_reverse,         // Segment order
   input wire logic       pixel_invert,        // Polarity
   input wire logic       all_pixels_on,       // Force on
   input wire logic       bias_fifth,          // Bias
   input wire logic [5:0] start_line,          // Start line
   input wire logic [4:0] refv_param,          // Reference
   input wire logic       busy,                // Busy
   input wire logic       init_busy            // Pin init
);
   // ************************************************************
   // Accepted command writes and the settings word
   // ************************************************************
   logic        take;
   logic        cmd_w;
   logic [15:0] sett;
   assign take  = req_valid && req_ready;
   assign cmd_w = take && !busy && hw_reset_n && !req_cmd_data_select
                  && !req_rw;
   assign sett  = {display_on, seg_reverse, pixel_invert, all_pixels_on,
                   bias_fifth, start_line, refv_param};
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   property p_disp;
      cmd_w && req_wdata[7:1] == lcdd_pkg::PAT_DISP
      |=> display_on == $past(req_wdata[0]);
   endproperty
   a_disp: assert property (p_disp)
      else $error("bad display enable");
   property p_seg;
      cmd_w && req_wdata[7:1] == lcdd_pkg::PAT_SEGDIR
      |=> seg_reverse == $past(req_wdata[0]);
   endproperty
   a_seg: assert property (p_seg)
      else $error("bad segment direction");
   property p_inv;
      cmd_w && req_wdata[7:1] == lcdd_pkg::PAT_INVERT
      |=> pixel_invert == $past(req_wdata[0]);
   endproperty
   a_inv: assert property (p_inv)
      else $error("bad polarity");
   property p_allon;
      cmd_w && req_wdata[7:1] == lcdd_pkg::PAT_ALLON
      |=> all_pixels_on == $past(req_wdata[0]);
   endproperty
   a_allon: assert property (p_allon)
      else $error("bad all-on");
   property p_bias;
      cmd_w && req_wdata[7:1] == lcdd_pkg::PAT_BIAS
      |=> bias_fifth == $past(req_wdata[0]);
   endproperty
   a_bias: assert property (p_bias)
      else $error("bad bias");
   property p_start;
      cmd_w && req_wdata[7:6] == lcdd_pkg::PAT_START
      |=> start_line == $past(req_wdata[5:0]);
   endproperty
   a_start: assert property (p_start)
      else $error("bad start line");
   property p_ign_busy;
      take && busy && !req_cmd_data_select && !req_rw |=> $stable(sett);
   endproperty
   a_ign_busy: assert property (p_ign_busy)
      else $error("acted while busy");
   property p_ign_unk;
      cmd_w && req_wdata == 8'hF0 |=> $stable(sett);
   endproperty
   a_ign_unk: assert property (p_ign_unk)
      else $error("unknown command acted");
   property p_init;
      init_busy |-> busy;
   endproperty
   a_init: assert property (p_init)
      else $error("init without busy");
   property p_rsp;
      take && req_rw |-> ##2 rsp_valid;
   endproperty
   a_rsp: assert property (p_rsp)
      else $error("read answer late");
   property p_wbusy;
      take && !busy && req_cmd_data_select && !req_rw |=> busy;
   endproperty
   a_wbusy: assert property (p_wbusy)
      else $error("write without busy");
   c_read: cover property (take && req_rw && req_cmd_data_select);
   c_full: cover property (rsp_valid && !rsp_ready && !req_ready);
   c_init: cover property ($fell(init_busy));
endmodule : lcdd_assertions
bind lcdd_decoder lcdd_assertions u_chk (
   .mclk, .resetn, .hw_reset_n, .serial_sel, .req_valid, .req_ready,
   .req_cmd_data_select, .req_rw, .req_wdata, .rsp_valid, .rsp_ready,
   .rsp_data, .scan_page, .scan_col, .scan_data, .display_on,
   .seg_reverse, .pixel_invert, .all_pixels_on, .bias_fifth, .start_line,
   .refv_param, .busy, .init_busy
);
`default_nettype wire

// *** testbench/lcdd_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcdd_host (
   input  wire logic       mclk,                // Clock
   input  wire logic       busy,                // Device busy
   input  wire logic       req_ready,           // Device takes request
   input  wire logic       rsp_valid,           // Read byte ready
   input  wire logic [7:0] rsp_data,            // Read byte
   input  wire logic       stall,               // Hold off pops
   output logic            req_valid,           // Request present
   output logic            req_cmd_data_select, // 1 data, 0 command
   output logic            req_rw,              // 1 read, 0 write
   output logic      [7:0] req_wdata,           // Write byte
   output logic            rsp_ready,           // Pop read byte
   output logic            hang                 // A wait ran out
);
   assign rsp_ready = !stall;
   initial {req_valid, req_cmd_data_select, req_rw, req_wdata, hang} = 12'h000;
   task automatic get(output logic [7:0] q);
      int n = 0;
      @(negedge mclk);
      while (rsp_valid !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      if (n == 100) hang = 1'b1;
      q = rsp_data;
   endtask : get
   task automatic xfer(input logic cds, input logic rw,
                       input logic [7:0] d, output logic [7:0] q);
      int n = 0;
      q = 8'h00;
      @(posedge mclk);
      req_valid <= 1'b1;
      req_cmd_data_select <= cds;
      req_rw <= rw;
      req_wdata <= d;
      @(negedge mclk);
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      @(posedge mclk);
      req_valid <= 1'b0;
      req_wdata <= ~d;
      if (rw && !stall) get(q);
      else if (!rw) begin
         @(posedge mclk);
         @(negedge mclk);
         while (busy !== 1'b0 && n < 200) begin
            @(negedge mclk);
            n++;
         end
      end
      if (n >= 100) hang = 1'b1;
   endtask : xfer
endmodule : lcdd_host
`default_nettype wire

// *** testbench/lcdd_decoder_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module lcdd_decoder_bench;
   localparam int INIT  = 8;
   localparam int LIMIT = 4000;
   localparam logic [23:0] ROWS [17] = '{
      24'hAF_8000, 24'hA1_C000, 24'hA7_E000, 24'hA5_F000, 24'hA3_F800,
      24'h7F_FFE0, 24'h81_FFE0, 24'h9F_FFFF, 24'hF0_FFFF, 24'h81_FFFF,
      24'h85_FFE5, 24'hAE_7FE5, 24'hA0_3FE5, 24'hA6_1FE5, 24'hA4_0FE5,
      24'hA2_07E5, 24'h40_0005};
   logic        mclk, resetn, hw_reset_n, serial_sel, stall, hang;
   logic        req_valid, req_ready, req_cmd_data_select, req_rw;
   logic        rsp_valid, rsp_ready, busy, init_busy;
   logic        display_on, seg_reverse, pixel_invert, all_pixels_on;
   logic        bias_fifth;
   logic [7:0]  req_wdata, rsp_data, scan_data, q;
   logic [3:0]  scan_page;
   logic [6:0]  scan_col;
   logic [5:0]  start_line;
   logic [4:0]  refv_param;
   logic [15:0] s;
   logic [23:0] r;
   int          n_errors, check_count, cycles;
   assign s = {display_on, seg_reverse, pixel_invert, all_pixels_on,
               bias_fifth, start_line, refv_param};
   initial mclk = 1'b0;
   always #2.5 mclk = ~mclk;
   lcdd_decoder #(.INIT_CYCLES(INIT), .FIFO_DEPTH(4)) dut (
      .mclk, .resetn, .hw_reset_n, .serial_sel, .req_valid, .req_ready,
      .req_cmd_data_select, .req_rw, .req_wdata, .rsp_valid, .rsp_ready,
      .rsp_data, .scan_page, .scan_col, .scan_data, .display_on,
      .seg_reverse, .pixel_invert, .all_pixels_on, .bias_fifth,
      .start_line, .refv_param, .busy, .init_busy);
   lcdd_host u_host (
      .mclk, .busy, .req_ready, .rsp_valid, .rsp_data, .stall, .req_valid,
      .req_cmd_data_select, .req_rw, .req_wdata, .rsp_ready, .hang);
   // ************************************************************
   // Helpers
   // ************************************************************
   task automatic chk_byte(input string w, input logic [7:0] e,
                           input logic [7:0] g);
      chk_word(w, 16'(e), 16'(g));
   endtask : chk_byte
   task automatic chk_word(input string w, input logic [15:0] e,
                           input logic [15:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("unexpected %s exp %h got %h", w, e, g);
      end
   endtask : chk_word
   task automatic cmd(input logic [7:0] d);
      u_host.xfer(1'b0, 1'b0, d, q);
   endtask : cmd
   task automatic wr(input logic [7:0] d);
      u_host.xfer(1'b1, 1'b0, d, q);
   endtask : wr
   task automatic rd(input logic cds);
      u_host.xfer(cds, 1'b1, 8'h00, q);
   endtask : rd
   task automatic report_and_stop;
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT || hang === 1'b1) begin
         n_errors++;
         report_and_stop;
      end
   end
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      {resetn, serial_sel, stall, n_errors, check_count, cycles} = '0;
      hw_reset_n = 1'b1;
      scan_page = 4'h8;
      scan_col = 7'h62;
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      cmd(8'hE3);
      chk_word("reset settings", 16'h0000, s);
      for (int i = 0; i < 17; i++) begin
         r = ROWS[i];
         cmd(r[23:16]);
         chk_word("flags", 16'(r[15:11]), 16'(s[15:11]));
         chk_word("values", 16'(r[10:0]), 16'(s[10:0]));
         rd(1'b0);
         chk_byte("status", {1'b0, ~r[14], ~r[15], 5'h00}, q);
      end
      @(posedge mclk);
      hw_reset_n <= 1'b0;
      repeat (4) @(posedge mclk);
      hw_reset_n <= 1'b1;
      rd(1'b0);
      chk_byte("init status", 8'hF0, q);
      cmd(8'hAF);
      chk_word("after pin reset", 16'h0000, s);
      chk_byte("init flag", 8'h00, {7'h00, init_busy});
      @(posedge mclk);
      stall <= 1'b1;
      repeat (4) rd(1'b0);
      repeat (3) @(negedge mclk);
      chk_byte("ready when full", 8'h00, {7'h00, req_ready});
      @(posedge mclk);
      stall <= 1'b0;
      repeat (4) begin
         u_host.get(q);
         chk_byte("queued status", 8'h60, q);
      end
      repeat (2) @(negedge mclk);
      chk_byte("drained", 8'h00, {7'h00, rsp_valid});
      cmd(8'hB8);
      cmd(8'h16);
      cmd(8'h02);
      wr(8'h5A);
      wr(8'hA5);
      cmd(8'h02);
      rd(1'b1);
      rd(1'b1);
      chk_byte("ram col 98", 8'h5A, q);
      rd(1'b1);
      chk_byte("ram col 99", 8'hA5, q);
      cmd(8'hB0);
      chk_byte("panel byte", 8'h5A, scan_data);
      cmd(8'hB8);
      cmd(8'h02);
      cmd(8'hE0);
      rd(1'b1);
      rd(1'b1);
      chk_byte("modify read", 8'h5A, q);
      rd(1'b1);
      chk_byte("modify reread", 8'h5A, q);
      wr(8'h3C);
      cmd(8'hEE);
      rd(1'b1);
      rd(1'b1);
      chk_byte("restored col", 8'h3C, q);
      @(posedge mclk);
      serial_sel <= 1'b1;
      rd(1'b1);
      rd(1'b1);
      chk_byte("serial read", 8'h00, q);
      report_and_stop;
   end
endmodule : lcdd_decoder_bench
`default_nettype wire
